// ===== wear_pkg.sv
// shared constants for the switchgear wear monitor
package wear_pkg;
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned HOUR_S = 3600;
  // one hour of cycles does not fit in 32 bits, so it is kept as a 64-bit constant
  localparam longint unsigned HOUR_CYCLES = 64'(CLK_HZ) * 64'(HOUR_S);
  localparam int unsigned CURVE_POINTS = 10;
  localparam int unsigned CUR_W = 16;
  localparam int unsigned SUM_W = 32;
  localparam int unsigned CNT_W = 32;
  localparam int unsigned PCT_W = 32;
  localparam int unsigned PCT_FRAC = 16;
  localparam logic [31:0] PCT_FULL = 32'h0064_0000;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_MASK = 8'h08;
  localparam logic [7:0] ADDR_OPLIM = 8'h0C;
  localparam logic [7:0] ADDR_SUMLIM = 8'h10;
  localparam logic [7:0] ADDR_HOURLIM = 8'h14;
  localparam logic [7:0] ADDR_TOPEN = 8'h18;
  localparam logic [7:0] ADDR_TCLOSE = 8'h1C;
  localparam logic [7:0] ADDR_OPCNT = 8'h20;
  localparam logic [7:0] ADDR_SUM0 = 8'h24;
  localparam logic [7:0] ADDR_HOURSUM = 8'h30;
  localparam logic [7:0] ADDR_PCT = 8'h34;
  localparam logic [7:0] ADDR_CURVE = 8'h40;
  localparam logic [7:0] ADDR_CURVE_END = 8'h90;
  localparam logic [3:0] NPTS_RST = 4'h0;
  localparam logic [31:0] OPLIM_RST = 32'hFFFF_FFFF;
  localparam logic [31:0] SUMLIM_RST = 32'hFFFF_FFFF;
  localparam logic [31:0] HOURLIM_RST = 32'hFFFF_FFFF;
  localparam logic [31:0] TMOVE_RST = 32'hFFFF_FFFF;
  localparam int unsigned EV_W = 8;
  localparam int unsigned EV_OPS = 0;
  localparam int unsigned EV_SUM = 1;
  localparam int unsigned EV_HOUR = 2;
  localparam int unsigned EV_SLOW = 3;
  localparam int unsigned EV_LIFE = 4;
  typedef enum logic [1:0] {ACC_IDLE, ACC_PHASE, ACC_LIFE} acc_t;
endpackage

// ===== travel_timer.sv
// measures open or close travel time and flags slow travel
`timescale 1ns/1ps
module travel_timer (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic start,
  input wire logic done,
  input wire logic [31:0] limit,
  output logic slow,
  output logic [31:0] measured
);
  import wear_pkg::*;
  logic running_q;
  logic [31:0] count_q;
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      running_q <= 1'b0;
      count_q <= '0;
      measured <= '0;
      slow <= 1'b0;
    end else begin
      slow <= 1'b0;
      if (start) begin
        running_q <= 1'b1;
        // the start edge is the first cycle of travel, so the count begins at one
        count_q <= 32'h1;
      end else if (running_q) begin
        count_q <= count_q + 32'h1;
        if (done) begin
          running_q <= 1'b0;
          measured <= count_q;
          slow <= (count_q > limit);
        end
      end
    end
  end
endmodule

// ===== wear_curve.sv
// wear curve storage and allowed-operations interpolation
`timescale 1ns/1ps
module wear_curve (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic wrEn,
  input wire logic [4:0] wrIdx,
  input wire logic [31:0] wrData,
  input wire logic [3:0] numPoints,
  input wire logic [wear_pkg::CUR_W-1:0] current,
  output logic [31:0] rdData,
  output logic [31:0] allowed
);
  import wear_pkg::*;
  // even index: current in kA, odd index: allowed operations
  logic [CUR_W-1:0] ka_q [CURVE_POINTS];
  logic [31:0] ops_q [CURVE_POINTS];
  logic [3:0] last;
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < CURVE_POINTS; i++) begin
        ka_q[i] <= '0;
        ops_q[i] <= '0;
      end
    end else if (wrEn && wrIdx < 5'd20) begin
      if (wrIdx[0]) ops_q[wrIdx[4:1]] <= wrData;
      else ka_q[wrIdx[4:1]] <= wrData[CUR_W-1:0];
    end
  end
  always_comb begin
    rdData = '0;
    if (wrIdx < 5'd20) begin
      rdData = wrIdx[0] ? ops_q[wrIdx[4:1]] : {16'h0000, ka_q[wrIdx[4:1]]};
    end
  end
  assign last = (numPoints == 4'h0) ? 4'h0 : numPoints - 4'h1;
  // combinational interpolation; one divide, kept off the bus path
  always_comb begin
    logic [31:0] loOps;
    logic [31:0] hiOps;
    logic [47:0] num;
    logic [CUR_W-1:0] span;
    loOps = '0;
    hiOps = '0;
    num = '0;
    span = '0;
    allowed = '0;
    if (numPoints == 4'h0 || current > ka_q[last]) begin
      allowed = '0;
    end else if (current <= ka_q[0]) begin
      allowed = (last == 4'h0) ? 32'h0 : ops_q[0];
    end else begin
      for (int i = 1; i < CURVE_POINTS; i++) begin
        if (4'(i) <= last && current > ka_q[i-1] && current <= ka_q[i]) begin
          loOps = ops_q[i-1];
          hiOps = (4'(i) == last) ? 32'h0 : ops_q[i];
          span = ka_q[i] - ka_q[i-1];
          num = 48'(loOps - hiOps) * 48'(ka_q[i] - current);
          allowed = (span == '0) ? hiOps : hiOps + 32'(num / 48'(span));
        end
      end
    end
  end
endmodule

// ===== switchgear_wear_monitor.sv
// top of the switchgear wear monitor with wishbone register slave
// **********************************************************************
// **********************************************************************
`timescale 1ns/1ps
module switchgear_wear_monitor (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic [7:0] adr_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  input wire logic [3:0] sel_i,
  input wire logic we_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  output logic ack_o,
  input wire logic openCmd,
  input wire logic closeCmd,
  input wire logic posOpen,
  input wire logic posClosed,
  input wire logic [wear_pkg::CUR_W-1:0] curPh1,
  input wire logic [wear_pkg::CUR_W-1:0] curPh2,
  input wire logic [wear_pkg::CUR_W-1:0] curPh3,
  output logic opsAlarm,
  output logic sumAlarm,
  output logic [2:0] sumPhaseAlarm,
  output logic hourly_current_sum_alarm,
  output logic slow_operation_flag,
  output logic maintenanceDue,
  output logic irq
);
  import wear_pkg::*;
  // **********************************************************************
  // input synchronisers
  // **********************************************************************
  logic [3:0] pinMeta_q;
  logic [3:0] pinSync_q;
  logic [3:0] pinPrev_q;
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      pinMeta_q <= '0;
      pinSync_q <= '0;
      pinPrev_q <= '0;
    end else begin
      pinMeta_q <= {posClosed, posOpen, closeCmd, openCmd};
      pinSync_q <= pinMeta_q;
      pinPrev_q <= pinSync_q;
    end
  end
  logic openRise;
  logic closeRise;
  logic openedRise;
  logic closedRise;
  assign openRise = pinSync_q[0] & ~pinPrev_q[0];
  assign closeRise = pinSync_q[1] & ~pinPrev_q[1];
  assign openedRise = pinSync_q[2] & ~pinPrev_q[2];
  assign closedRise = pinSync_q[3] & ~pinPrev_q[3];
  // currents are sampled magnitudes, assumed stable around an opening
  logic [CUR_W-1:0] curMeta_q [3];
  logic [CUR_W-1:0] cur_q [3];
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      for (int p = 0; p < 3; p++) begin
        curMeta_q[p] <= '0;
        cur_q[p] <= '0;
      end
    end else begin
      curMeta_q[0] <= curPh1;
      curMeta_q[1] <= curPh2;
      curMeta_q[2] <= curPh3;
      for (int p = 0; p < 3; p++) cur_q[p] <= curMeta_q[p];
    end
  end
  // **********************************************************************
  // software registers
  // **********************************************************************
  logic [3:0] numPoints_q;
  logic [31:0] opLimit_q;
  logic [31:0] sumLimit_q;
  logic [31:0] hourLimit_q;
  logic [31:0] tOpen_q;
  logic [31:0] tClose_q;
  logic [EV_W-1:0] status_q;
  logic [EV_W-1:0] mask_q;
  logic [31:0] operation_count_q;
  logic [SUM_W-1:0] interrupted_current_sum_phase_q [3];
  logic [SUM_W-1:0] hourSum_q;
  logic [PCT_W-1:0] wear_consumed_percent_q;
  logic busReq;
  logic busWr;
  logic curveHit;
  logic [4:0] curveIdx;
  logic [31:0] curveRd;
  logic [31:0] allowed;
  logic [CUR_W-1:0] curMax_q;
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] sel);
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) old[b*8 +: 8] = nw[b*8 +: 8];
    end
    return old;
  endfunction
  assign busReq = cyc_i & stb_i & ~ack_o;
  assign busWr = busReq & we_i;
  assign curveHit = adr_i >= ADDR_CURVE && adr_i < ADDR_CURVE_END;
  assign curveIdx = 5'((adr_i - ADDR_CURVE) >> 2);
  // one wait-free answer: ack the cycle after the request is seen
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) ack_o <= 1'b0;
    else ack_o <= busReq;
  end
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      numPoints_q <= NPTS_RST;
      opLimit_q <= OPLIM_RST;
      sumLimit_q <= SUMLIM_RST;
      hourLimit_q <= HOURLIM_RST;
      tOpen_q <= TMOVE_RST;
      tClose_q <= TMOVE_RST;
      mask_q <= '0;
    end else if (busWr) begin
      case (adr_i)
        ADDR_CTRL: numPoints_q <= (dat_i[3:0] > 4'd10) ? 4'd10 : dat_i[3:0];
        ADDR_MASK: mask_q <= EV_W'(merge({24'h0, mask_q}, dat_i, sel_i));
        ADDR_OPLIM: opLimit_q <= merge(opLimit_q, dat_i, sel_i);
        ADDR_SUMLIM: sumLimit_q <= merge(sumLimit_q, dat_i, sel_i);
        ADDR_HOURLIM: hourLimit_q <= merge(hourLimit_q, dat_i, sel_i);
        ADDR_TOPEN: tOpen_q <= merge(tOpen_q, dat_i, sel_i);
        ADDR_TCLOSE: tClose_q <= merge(tClose_q, dat_i, sel_i);
        default: ;
      endcase
    end
  end
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) dat_o <= '0;
    else if (busReq && !we_i) begin
      if (curveHit) dat_o <= curveRd;
      else begin
        case (adr_i)
          ADDR_CTRL: dat_o <= {28'h0, numPoints_q};
          ADDR_STATUS: dat_o <= {24'h0, status_q};
          ADDR_MASK: dat_o <= {24'h0, mask_q};
          ADDR_OPLIM: dat_o <= opLimit_q;
          ADDR_SUMLIM: dat_o <= sumLimit_q;
          ADDR_HOURLIM: dat_o <= hourLimit_q;
          ADDR_TOPEN: dat_o <= tOpen_q;
          ADDR_TCLOSE: dat_o <= tClose_q;
          ADDR_OPCNT: dat_o <= operation_count_q;
          8'h24: dat_o <= interrupted_current_sum_phase_q[0];
          8'h28: dat_o <= interrupted_current_sum_phase_q[1];
          8'h2C: dat_o <= interrupted_current_sum_phase_q[2];
          ADDR_HOURSUM: dat_o <= hourSum_q;
          ADDR_PCT: dat_o <= wear_consumed_percent_q;
          default: dat_o <= '0;
        endcase
      end
    end
  end
  wear_curve curve (
    .clock(clock),
    .arst_n(arst_n),
    .wrEn(busWr && curveHit),
    .wrIdx(curveIdx),
    .wrData(dat_i),
    .numPoints(numPoints_q),
    .current(curMax_q),
    .rdData(curveRd),
    .allowed(allowed)
  );
  // **********************************************************************
  // operations, sums and life
  // **********************************************************************
  acc_t accState_q;
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      operation_count_q <= '0;
      curMax_q <= '0;
      accState_q <= ACC_IDLE;
      wear_consumed_percent_q <= '0;
      for (int p = 0; p < 3; p++) interrupted_current_sum_phase_q[p] <= '0;
    end else begin
      if (openRise || closeRise) operation_count_q <= operation_count_q + 32'h1;
      case (accState_q)
        ACC_IDLE: if (openRise) accState_q <= ACC_PHASE;
        ACC_PHASE: begin
          for (int p = 0; p < 3; p++) begin
            interrupted_current_sum_phase_q[p] <=
              interrupted_current_sum_phase_q[p] + SUM_W'(cur_q[p]);
          end
          curMax_q <= (cur_q[0] > cur_q[1]) ? ((cur_q[0] > cur_q[2]) ? cur_q[0] : cur_q[2])
                      : ((cur_q[1] > cur_q[2]) ? cur_q[1] : cur_q[2]);
          accState_q <= ACC_LIFE;
        end
        ACC_LIFE: begin
          // life cost uses the worst phase; fixed point with 16 fraction bits
          if (allowed == '0 || wear_consumed_percent_q >= PCT_FULL)
            wear_consumed_percent_q <= PCT_FULL;
          else if (PCT_FULL - wear_consumed_percent_q <= PCT_FULL / allowed)
            wear_consumed_percent_q <= PCT_FULL;
          else wear_consumed_percent_q <= wear_consumed_percent_q + PCT_FULL / allowed;
          accState_q <= ACC_IDLE;
        end
        default: accState_q <= ACC_IDLE;
      endcase
    end
  end
  // hourly window: fixed one-hour windows, sum restarts at each window edge
  logic [37:0] hourTimer_q;
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      hourTimer_q <= '0;
      hourSum_q <= '0;
    end else begin
      if (hourTimer_q == 38'(HOUR_CYCLES - 64'd1)) begin
        hourTimer_q <= '0;
        hourSum_q <= '0;
      end else begin
        hourTimer_q <= hourTimer_q + 38'h1;
        if (accState_q == ACC_PHASE) begin
          hourSum_q <= hourSum_q + SUM_W'(cur_q[0]) + SUM_W'(cur_q[1]) + SUM_W'(cur_q[2]);
        end
      end
    end
  end
  // **********************************************************************
  // travel time supervision
  // **********************************************************************
  logic slowOpen;
  logic slowClose;
  travel_timer openTimer (
    .clock(clock),
    .arst_n(arst_n),
    .start(openRise),
    .done(openedRise),
    .limit(tOpen_q),
    .slow(slowOpen),
    .measured()
  );
  travel_timer closeTimer (
    .clock(clock),
    .arst_n(arst_n),
    .start(closeRise),
    .done(closedRise),
    .limit(tClose_q),
    .slow(slowClose),
    .measured()
  );
  // **********************************************************************
  // alarms and interrupt
  // **********************************************************************
  logic [2:0] phOver;
  logic [EV_W-1:0] events;
  always_comb begin
    for (int p = 0; p < 3; p++) phOver[p] = interrupted_current_sum_phase_q[p] > sumLimit_q;
  end
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      opsAlarm <= 1'b0;
      sumAlarm <= 1'b0;
      sumPhaseAlarm <= '0;
      hourly_current_sum_alarm <= 1'b0;
      slow_operation_flag <= 1'b0;
      maintenanceDue <= 1'b0;
    end else begin
      opsAlarm <= operation_count_q > opLimit_q;
      sumAlarm <= |phOver;
      sumPhaseAlarm <= phOver;
      hourly_current_sum_alarm <= hourSum_q > hourLimit_q;
      // slow flag latches until the next operation starts
      if (slowOpen || slowClose) slow_operation_flag <= 1'b1;
      else if (openRise || closeRise) slow_operation_flag <= 1'b0;
      maintenanceDue <= wear_consumed_percent_q >= PCT_FULL;
    end
  end
  always_comb begin
    events = '0;
    events[EV_OPS] = opsAlarm;
    events[EV_SUM] = sumAlarm;
    events[EV_HOUR] = hourly_current_sum_alarm;
    events[EV_SLOW] = slowOpen | slowClose;
    events[EV_LIFE] = maintenanceDue;
  end
  // set wins over a write-one clear in the same cycle
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) status_q <= '0;
    else if (busWr && adr_i == ADDR_STATUS && sel_i[0])
      status_q <= (status_q & ~dat_i[EV_W-1:0]) | events;
    else status_q <= status_q | events;
  end
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) irq <= 1'b0;
    else irq <= |(status_q & mask_q);
  end
endmodule

// ===== wear_monitor_checker_props.sv
// checker for the switchgear wear monitor ports
`timescale 1ns/1ps
module wear_monitor_checker (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic ack_o,
  input wire logic openCmd,
  input wire logic closeCmd,
  input wire logic opsAlarm,
  input wire logic sumAlarm,
  input wire logic [2:0] sumPhaseAlarm,
  input wire logic hourly_current_sum_alarm,
  input wire logic slow_operation_flag,
  input wire logic maintenanceDue
);
  // ****
  // cycles since the last command edge or register write
  // ****
  logic [4:0] since_q;
  logic openPrev_q;
  logic closePrev_q;
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      since_q <= 5'h1F;
      openPrev_q <= 1'b0;
      closePrev_q <= 1'b0;
    end else begin
      openPrev_q <= openCmd;
      closePrev_q <= closeCmd;
      if ((openCmd && !openPrev_q) || (closeCmd && !closePrev_q) || (ack_o && we_i)) begin
        since_q <= 5'h00;
      end else if (since_q != 5'h1F) begin
        since_q <= since_q + 5'h01;
      end
    end
  end
  // ****
  // properties: one-cycle ack, and alarms only rise or the slow flag clear after a cause, within the sync and pipeline depth
  // ****
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!arst_n);
  sequence s_req;
    cyc_i && stb_i && !ack_o;
  endsequence
  sequence s_recent;
    since_q <= 5'h0A;
  endsequence
  property p_ack_answer;
    s_req |=> ack_o;
  endproperty
  a_ack_answer: assert property (p_ack_answer) else $error("request not acknowledged");
  property p_ack_pulse;
    ack_o |=> !ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
  property p_ops_cause;
    $rose(opsAlarm) |-> s_recent;
  endproperty
  a_ops_cause: assert property (p_ops_cause) else $error("ops alarm without cause");
  property p_sum_any;
    sumAlarm == (|sumPhaseAlarm);
  endproperty
  a_sum_any: assert property (p_sum_any) else $error("sum alarm disagrees");
  property p_sum_cause;
    $rose(|sumPhaseAlarm) |-> s_recent;
  endproperty
  a_sum_cause: assert property (p_sum_cause) else $error("phase alarm without cause");
  property p_hour_cause;
    $rose(hourly_current_sum_alarm) |-> s_recent;
  endproperty
  a_hour_cause: assert property (p_hour_cause) else $error("hour alarm without cause");
  property p_life_hold;
    maintenanceDue |=> maintenanceDue;
  endproperty
  a_life_hold: assert property (p_life_hold) else $error("maintenance flag dropped");
  property p_life_cause;
    $rose(maintenanceDue) |-> s_recent;
  endproperty
  a_life_cause: assert property (p_life_cause) else $error("maintenance without cause");
  property p_slow_clear;
    $fell(slow_operation_flag) |-> s_recent;
  endproperty
  a_slow_clear: assert property (p_slow_clear) else $error("slow flag cleared idle");
endmodule

bind switchgear_wear_monitor wear_monitor_checker i_wear_monitor_checker (
  .clock(clock), .arst_n(arst_n), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .ack_o(ack_o),
  .openCmd(openCmd), .closeCmd(closeCmd), .opsAlarm(opsAlarm), .sumAlarm(sumAlarm),
  .sumPhaseAlarm(sumPhaseAlarm), .hourly_current_sum_alarm(hourly_current_sum_alarm),
  .slow_operation_flag(slow_operation_flag), .maintenanceDue(maintenanceDue)
);

// ===== breaker_model.sv
// breaker model: contact travel, position contacts and phase currents
`timescale 1ns/1ps
module breaker_model (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic openCmd,
  input wire logic closeCmd,
  input wire logic [7:0] travel,
  input wire logic [15:0] load1,
  input wire logic [15:0] load2,
  input wire logic [15:0] load3,
  output logic posOpen,
  output logic posClosed,
  output logic [15:0] curPh1,
  output logic [15:0] curPh2,
  output logic [15:0] curPh3
);
  logic openPrev_q;
  logic closePrev_q;
  logic toOpen_q;
  logic carry_q;
  logic [7:0] left_q;
  // current flows until the contacts part, so it is gone once travel ends
  assign curPh1 = carry_q ? load1 : 16'h0000;
  assign curPh2 = carry_q ? load2 : 16'h0000;
  assign curPh3 = carry_q ? load3 : 16'h0000;
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      openPrev_q <= 1'b0;
      closePrev_q <= 1'b0;
      toOpen_q <= 1'b0;
      carry_q <= 1'b1;
      left_q <= 8'h00;
      posOpen <= 1'b0;
      posClosed <= 1'b1;
    end else begin
      openPrev_q <= openCmd;
      closePrev_q <= closeCmd;
      if (openCmd && !openPrev_q) begin
        posClosed <= 1'b0;
        toOpen_q <= 1'b1;
        left_q <= travel;
      end else if (closeCmd && !closePrev_q) begin
        posOpen <= 1'b0;
        toOpen_q <= 1'b0;
        left_q <= travel;
      end else if (left_q == 8'h01) begin
        posOpen <= toOpen_q;
        posClosed <= !toOpen_q;
        carry_q <= !toOpen_q;
        left_q <= 8'h00;
      end else if (left_q != 8'h00) begin
        left_q <= left_q - 8'h01;
      end
    end
  end
endmodule

// ===== switchgear_wear_monitor_tb_top.sv
// self-checking testbench for the switchgear wear monitor
`timescale 1ns/1ps
module switchgear_wear_monitor_tb_top;
  import wear_pkg::*;
  logic clock = 1'b0;
  logic arst_n = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] datI = 32'h0;
  logic [3:0] sel = 4'h0;
  logic we = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic openCmd = 1'b0;
  logic closeCmd = 1'b0;
  logic [7:0] travel = 8'h08;
  logic [15:0] load [3] = '{default: 16'h0};
  logic [15:0] cur [3];
  logic [31:0] datO;
  logic [31:0] rd;
  logic [2:0] sumPh;
  logic ack, posOpen, posClosed, opsAlarm, sumAlarm, hourAlarm, slowFlag, due, irq;
  int fails = 0;
  int totalChecks = 0;
  int cnt = 0;
  int pct = 0;
  int stat = 0;
  int lvl = 0;
  int sum [3] = '{0, 0, 0};
  int lim [5] = '{4, 40, 0, 24, 24};
  int crv [6] = '{10, 512, 20, 128, 30, 999};
  int cs [6][3] = '{'{5, 8, 8}, '{15, 40, 8}, '{20, 8, 40}, '{25, 8, 8}, '{10, 25, 8}, '{35, 8, 8}};
  always #12.5 clock = ~clock;
  switchgear_wear_monitor i_switchgear_wear_monitor (.clock(clock), .arst_n(arst_n),
    .adr_i(adr), .dat_i(datI), .dat_o(datO), .sel_i(sel), .we_i(we), .cyc_i(cyc), .stb_i(stb),
    .ack_o(ack), .openCmd(openCmd), .closeCmd(closeCmd), .posOpen(posOpen),
    .posClosed(posClosed), .curPh1(cur[0]), .curPh2(cur[1]), .curPh3(cur[2]),
    .opsAlarm(opsAlarm), .sumAlarm(sumAlarm), .sumPhaseAlarm(sumPh),
    .hourly_current_sum_alarm(hourAlarm), .slow_operation_flag(slowFlag),
    .maintenanceDue(due), .irq(irq));
  breaker_model i_breaker_model (.clock(clock), .arst_n(arst_n), .openCmd(openCmd),
    .closeCmd(closeCmd), .travel(travel), .load1(load[0]), .load2(load[1]), .load3(load[2]),
    .posOpen(posOpen), .posClosed(posClosed), .curPh1(cur[0]), .curPh2(cur[1]),
    .curPh3(cur[2]));
  // ****
  // checking and bus tasks
  // ****
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    totalChecks++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task testDone;
    $display("checks %0d mismatches %0d", totalChecks, fails);
    if (fails == 0 && totalChecks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task wb(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input logic w);
    int n;
    n = 0;
    adr <= a;
    datI <= d;
    sel <= s;
    we <= w;
    cyc <= 1'b1;
    stb <= 1'b1;
    do begin
      @(posedge clock);
      n++;
    end while (ack !== 1'b1 && n < 40);
    rd = datO;
    if (n >= 40) begin
      fails++;
      testDone;
    end
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clock);
  endtask
  task rdChk(input string nm, input logic [7:0] a, input logic [31:0] exp);
    wb(a, 32'h0, 4'hF, 1'b0);
    chk(nm, rd, exp);
  endtask
  // ****
  // reference model of one switching operation
  // ****
  function automatic int allowed(input int c);
    if (c <= 10) return 512;
    if (c <= 20) return 512 - (c - 10) * 384 / 10;
    if (c <= 30) return 128 - (c - 20) * 128 / 10;
    return 0;
  endfunction
  task checkAll(input int slowExp);
    int sp;
    sp = (sum[0] > 40) | (sum[1] > 40) << 1 | (sum[2] > 40) << 2;
    lvl = (cnt > 4) | (sp != 0) << 1 | (sum[0] + sum[1] + sum[2] > 0) << 2;
    lvl = lvl | slowExp << 3 | (pct >= PCT_FULL) << 4;
    stat = stat | lvl;
    rdChk("count", ADDR_OPCNT, cnt);
    for (int i = 0; i < 3; i++) rdChk("phaseSum", ADDR_SUM0 + 8'(4 * i), sum[i]);
    rdChk("percent", ADDR_PCT, pct);
    chk("opsAlarm", opsAlarm, lvl[0]);
    chk("sumAlarms", {sumPh, sumAlarm}, {sp[2:0], lvl[1]});
    chk("hourAlarm", hourAlarm, lvl[2]);
    chk("slowFlag", slowFlag, lvl[3]);
    chk("maintDue", due, lvl[4]);
  endtask
  task operate(input int c, input int tOpen, input int tClose);
    int k;
    int m;
    k = $urandom_range(2, 0);
    for (int i = 0; i < 3; i++) load[i] <= (i == k) ? 16'(c) : 16'($urandom_range(c, 0));
    travel <= 8'(tOpen);
    openCmd <= 1'b1;
    repeat (4) @(posedge clock);
    openCmd <= 1'b0;
    repeat (tOpen + 16) @(posedge clock);
    cnt++;
    for (int i = 0; i < 3; i++) sum[i] += load[i];
    m = allowed(c);
    pct = (m == 0 || pct + 6553600 / m >= PCT_FULL) ? PCT_FULL : pct + 6553600 / m;
    checkAll(tOpen > 24);
    travel <= 8'(tClose);
    closeCmd <= 1'b1;
    repeat (4) @(posedge clock);
    closeCmd <= 1'b0;
    repeat (tClose + 16) @(posedge clock);
    cnt++;
    checkAll(tClose > 24);
  endtask
  // ****
  // main sequence
  // ****
  initial begin
    rd = $urandom(32'h6AEEAFAF);
    repeat (4) @(posedge clock);
    arst_n <= 1'b1;
    @(posedge clock);
    chk("resetOuts", {23'h0, opsAlarm, sumAlarm, sumPh, hourAlarm, slowFlag, due, irq}, 0);
    for (int a = 12; a <= 28; a += 4) rdChk("limitReset", 8'(a), 32'hFFFF_FFFF);
    wb(8'h38, 32'h1234_5678, 4'hF, 1'b1);
    rdChk("unmapped", 8'h38, 32'h0);
    wb(ADDR_OPLIM, 32'h0000_0004, 4'h1, 1'b1);
    rdChk("opLimitLane", ADDR_OPLIM, 32'hFFFF_FF04);
    for (int i = 0; i < 5; i++) wb(ADDR_OPLIM + 8'(4 * i), lim[i], 4'hF, 1'b1);
    wb(ADDR_MASK, 32'h0, 4'hF, 1'b1);
    for (int i = 0; i < 6; i++) wb(ADDR_CURVE + 8'(4 * i), crv[i], 4'hF, 1'b1);
    wb(ADDR_CTRL, 32'h3, 4'hF, 1'b1);
    rdChk("curveOps", ADDR_CURVE + 8'h04, 32'd512);
    wb(ADDR_CURVE + 8'h4C, 32'h55, 4'hF, 1'b1);
    rdChk("curveLastOps", ADDR_CURVE + 8'h4C, 32'h55);
    chk("hourIdle", hourAlarm, 0);
    for (int i = 0; i < 6; i++) begin
      if (i == 3) chk("irqMasked", irq, 0);
      operate(cs[i][0], cs[i][1], cs[i][2]);
    end
    rdChk("status", ADDR_STATUS, stat);
    wb(ADDR_MASK, 32'h1F, 4'hF, 1'b1);
    repeat (2) @(posedge clock);
    chk("irqRaised", irq, 1);
    wb(ADDR_STATUS, 32'h1F, 4'h1, 1'b1);
    rdChk("statusClear", ADDR_STATUS, lvl);
    wb(ADDR_MASK, 32'h8, 4'hF, 1'b1);
    repeat (2) @(posedge clock);
    chk("irqCleared", irq, 0);
    testDone;
  end
  // watchdog sized well above the roughly 700 cycles the sequence needs
  initial begin
    repeat (20000) @(posedge clock);
    fails++;
    testDone;
  end
endmodule
